// File: hw/dsau_pkg.sv
// Purpose: Shared constants of the data-space access unit.
// Assumes: One core clock; byte effective addresses of 16 bits.
// Notes:   Function list of the block follows.
//
// Function
// - EA bit 15 with window enabled reads program memory, not data RAM.
// - Upper 32 Kbyte data window maps onto one selectable 16K word page.
// - Program address is page value above EA bits 14:1, with bit 0 forced to zero.
// - Window reads deliver only the low 16 bits of the program word.
// - Window mapping is off while a table read or write runs.
// - Outside repeat: one extra cycle for short class, two otherwise.
// - Inside repeat: two extra cycles on edge iterations, none elsewhere.
// - X covers all 64 Kbytes, except the Y block for MAC-class reads.
// - MAC-class reads use X pointers for X, Y pointers for Y, together.
// - Unimplemented or wrong-space operand addresses read as zero.
// - Y path is read-only; every write goes over the X write path.
// - Modulo on X and Y; bit-reversed only for X writes.
// - Effective addresses are 16-bit byte addresses over 16-bit words.
// - Byte read takes the word, EA bit 0 picks byte onto low lane.
// - Y path fetches whole words only.
// - Byte write strobes only the lane matching the byte address.
// - Post-increment steps by 1 for bytes and by 2 for words.
// - Misaligned X word access traps; read completes, write suppressed.
// - Byte load into a working register keeps its upper byte.
package dsau_pkg;
    localparam int          EA_W       = 16;
    localparam int          WORD_W     = 16;
    localparam int          PM_W       = 24;
    localparam int          PAGE_W     = 8;
    localparam int          WIN_BIT    = 15;
    localparam logic [1:0]  EXTRA_NONE  = 2'h0;
    localparam logic [1:0]  EXTRA_SHORT = 2'h1;
    localparam logic [1:0]  EXTRA_LONG  = 2'h2;
    localparam logic [1:0]  EXTRA_EDGE  = 2'h2;
    localparam logic [15:0] STEP_BYTE  = 16'h0001;
    localparam logic [15:0] STEP_WORD  = 16'h0002;
    localparam logic [15:0] ZERO_WORD  = 16'h0000;
    localparam logic [1:0]  LANE_LOW   = 2'h1;
    localparam logic [1:0]  LANE_HIGH  = 2'h2;
    localparam logic [1:0]  LANE_BOTH  = 2'h3;
    localparam logic [1:0]  LANE_NONE  = 2'h0;
    localparam logic [15:0] Y_FIRST_DEF  = 16'h0800;
    localparam logic [15:0] Y_LAST_DEF   = 16'h0fff;
    localparam logic [15:0] RAM_LAST_DEF = 16'h1fff;
endpackage

// File: hw/dsau_agu_if.sv
// Purpose: Carrier between core and post-modify address unit.
// Assumes: Purely combinational exchange inside one cycle.
// Notes:   One instance per data path.
interface dsau_agu_if;
    logic [15:0] ptr;
    logic [15:0] mod_start;
    logic [15:0] mod_end;
    logic [15:0] brev_mod;
    logic [15:0] ptr_next;
    logic        byte_op;
    logic        is_write;
    logic        is_y;
    logic        mod_en;
    logic        brev_en;
    modport agu  (input  ptr, mod_start, mod_end, brev_mod, byte_op,
                  is_write, is_y, mod_en, brev_en, output ptr_next);
    modport core (output ptr, mod_start, mod_end, brev_mod, byte_op,
                  is_write, is_y, mod_en, brev_en, input ptr_next);
endinterface

// File: hw/dsau_agu.sv
// Purpose: Post-modified pointer value for one data path.
// Assumes: Increment-only post modification.
// Notes:   Modulo wraps past the end back to the start.
module dsau_agu (
    dsau_agu_if.agu bus
);
    // Reverse bit order of a 16-bit value
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    logic [15:0] step;
    logic [15:0] inc;
    logic [15:0] brev_sum;

    // Step scaled to operand size
    assign step     = bus.byte_op ? dsau_pkg::STEP_BYTE
                                  : dsau_pkg::STEP_WORD;
    assign inc      = bus.ptr + step;
    assign brev_sum = rev16(bus.ptr) + rev16(bus.brev_mod);

    // Reverse-carry only on X writes; Y keeps plain or modulo stepping
    always_comb begin
        if (bus.brev_en && bus.is_write && !bus.is_y) begin
            bus.ptr_next = rev16(brev_sum);
        end else if (bus.mod_en && (inc > bus.mod_end)) begin
            bus.ptr_next = bus.mod_start;
        end else begin
            bus.ptr_next = inc;
        end
    end
endmodule

// File: hw/dsau_top.sv
// Purpose: Data-space decode, X/Y read paths, X write path, window.
// Assumes: RAM and program memory answer reads in the same cycle.
// Notes:   Requests come from pipeline logic on the same clock.
module dsau_top #(
    parameter logic [15:0] Y_FIRST  = dsau_pkg::Y_FIRST_DEF,
    parameter logic [15:0] Y_LAST   = dsau_pkg::Y_LAST_DEF,
    parameter logic [15:0] RAM_LAST = dsau_pkg::RAM_LAST_DEF
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        REQ_VALID_I,
    output logic             REQ_READY_O,
    input  wire logic        REQ_WRITE_I,
    input  wire logic        REQ_BYTE_I,
    input  wire logic        REQ_MAC_I,
    input  wire logic        REQ_SHORT_I,
    input  wire logic [15:0] REQ_EA_I,
    input  wire logic [15:0] REQ_WDATA_I,
    input  wire logic        REQ_XPTR_SEL_I,
    input  wire logic        REQ_YPTR_SEL_I,
    input  wire logic [15:0] X_POINTER_A_I,
    input  wire logic [15:0] X_POINTER_B_I,
    input  wire logic [15:0] Y_POINTER_A_I,
    input  wire logic [15:0] Y_POINTER_B_I,
    input  wire logic [15:0] WREG_OLD_I,
    input  wire logic        TABLE_ACTIVE_I,
    input  wire logic        IN_REPEAT_I,
    input  wire logic        REPEAT_EDGE_I,
    input  wire logic        PROGRAM_WINDOW_ENABLE_I,
    input  wire logic [7:0]  PROGRAM_WINDOW_PAGE_I,
    input  wire logic        X_MOD_EN_I,
    input  wire logic [15:0] X_MOD_START_I,
    input  wire logic [15:0] X_MOD_END_I,
    input  wire logic        BREV_EN_I,
    input  wire logic [15:0] BREV_MOD_I,
    input  wire logic        Y_MOD_EN_I,
    input  wire logic [15:0] Y_MOD_START_I,
    input  wire logic [15:0] Y_MOD_END_I,
    output logic             RESP_VALID_O,
    output logic [15:0]      X_RDATA_O,
    output logic [15:0]      Y_RDATA_O,
    output logic [15:0]      LOAD_DATA_O,
    output logic [15:0]      X_PTR_NEXT_O,
    output logic [15:0]      Y_PTR_NEXT_O,
    output logic             ADDR_ERR_TRAP_O,
    output logic [14:0]      RAM_RADDR_O,
    input  wire logic [15:0] RAM_RDATA_I,
    output logic [14:0]      YRAM_RADDR_O,
    input  wire logic [15:0] YRAM_RDATA_I,
    output logic [14:0]      RAM_WADDR_O,
    output logic [15:0]      RAM_WDATA_O,
    output logic [1:0]       RAM_WE_O,
    output logic [23:0]      PM_ADDR_O,
    output logic             PM_RD_O,
    input  wire logic [23:0] PM_RDATA_I
);
    //--------------------------------------------------------------
    // Request decode
    //--------------------------------------------------------------
    logic        accept;
    logic        mac_rd;
    logic [15:0] x_ea;
    logic [15:0] y_ea;
    logic        x_in_y;
    logic        y_in_y;
    logic        win_hit;
    logic        win_rd;
    logic        ram_hit;
    logic        x_invalid;
    logic        misalign;
    logic [1:0]  extra;
    logic [23:0] pm_addr_now;
    logic [15:0] x_word;
    logic [15:0] x_fmt;
    logic [15:0] load_fmt;
    logic [1:0]  lanes;

    logic [1:0]  cnt_reg;
    logic [23:0] pend_pm_reg;
    logic        pend_byte_reg;
    logic        pend_lane_reg;
    logic [7:0]  pend_hi_reg;
    logic        pend_trap_reg;
    logic        resp_valid_reg;
    logic [15:0] x_rdata_reg;
    logic [15:0] y_rdata_reg;
    logic [15:0] load_reg;
    logic        trap_reg;
    logic [15:0] x_next_reg;
    logic [15:0] y_next_reg;
    logic [14:0] waddr_reg;
    logic [15:0] wdata_reg;
    logic [1:0]  we_reg;

    // Stall while a window access is stretched
    assign REQ_READY_O = (cnt_reg == dsau_pkg::EXTRA_NONE);
    assign accept      = REQ_VALID_I && REQ_READY_O;
    assign mac_rd      = REQ_MAC_I && !REQ_WRITE_I;

    // Dual-operand reads only through their own pointer pairs
    assign x_ea = mac_rd ? (REQ_XPTR_SEL_I ? X_POINTER_B_I
                                           : X_POINTER_A_I)
                         : REQ_EA_I;
    assign y_ea = REQ_YPTR_SEL_I ? Y_POINTER_B_I : Y_POINTER_A_I;

    // Y block bounds are fixed by the build, not by software
    assign x_in_y = (x_ea >= Y_FIRST) && (x_ea <= Y_LAST);
    assign y_in_y = (y_ea >= Y_FIRST) && (y_ea <= Y_LAST);

    // Window is muted during table instructions
    assign win_hit = x_ea[dsau_pkg::WIN_BIT] && PROGRAM_WINDOW_ENABLE_I
                     && !TABLE_ACTIVE_I;
    assign win_rd  = win_hit && !REQ_WRITE_I;
    assign ram_hit = (x_ea <= RAM_LAST);

    // X excludes the Y block only for dual-operand reads
    assign x_invalid = (!win_hit && !ram_hit)
                       || (mac_rd && x_in_y);
    assign misalign  = !REQ_BYTE_I && x_ea[0];

    // Page value above the low fifteen address bits
    assign pm_addr_now = {1'b0, PROGRAM_WINDOW_PAGE_I,
                          x_ea[14:1], 1'b0};

    // Extra cycles for a window read
    always_comb begin
        if (!win_rd) begin
            extra = dsau_pkg::EXTRA_NONE;
        end else if (IN_REPEAT_I) begin
            extra = REPEAT_EDGE_I ? dsau_pkg::EXTRA_EDGE
                                  : dsau_pkg::EXTRA_NONE;
        end else begin
            extra = REQ_SHORT_I ? dsau_pkg::EXTRA_SHORT
                                : dsau_pkg::EXTRA_LONG;
        end
    end

    // Memory addresses follow the live request or the held window
    assign RAM_RADDR_O  = x_ea[15:1];
    assign YRAM_RADDR_O = y_ea[15:1];
    assign PM_ADDR_O    = REQ_READY_O ? pm_addr_now : pend_pm_reg;
    assign PM_RD_O      = !REQ_READY_O || (accept && win_rd);

    // Only the low program word carries data
    assign x_word = x_invalid ? dsau_pkg::ZERO_WORD
                  : (win_hit ? PM_RDATA_I[15:0] : RAM_RDATA_I);

    // Byte goes to the low lane; loads keep the register upper byte
    always_comb begin
        if (REQ_BYTE_I) begin
            x_fmt    = {8'h00, x_ea[0] ? x_word[15:8]
                                       : x_word[7:0]};
            load_fmt = {WREG_OLD_I[15:8], x_fmt[7:0]};
        end else begin
            x_fmt    = x_word;
            load_fmt = x_word;
        end
    end

    // Byte writes strobe a single lane
    always_comb begin
        if (REQ_BYTE_I) begin
            lanes = x_ea[0] ? dsau_pkg::LANE_HIGH
                            : dsau_pkg::LANE_LOW;
        end else begin
            lanes = dsau_pkg::LANE_BOTH;
        end
    end

    //--------------------------------------------------------------
    // Post-modify units
    //--------------------------------------------------------------
    dsau_agu_if x_agu ();
    dsau_agu_if y_agu ();

    assign x_agu.ptr       = x_ea;
    assign x_agu.byte_op   = REQ_BYTE_I;
    assign x_agu.is_write  = REQ_WRITE_I;
    assign x_agu.is_y      = 1'b0;
    assign x_agu.mod_en    = X_MOD_EN_I;
    assign x_agu.mod_start = X_MOD_START_I;
    assign x_agu.mod_end   = X_MOD_END_I;
    assign x_agu.brev_en   = BREV_EN_I;
    assign x_agu.brev_mod  = BREV_MOD_I;

    // Y side is word-only and never bit-reversed
    assign y_agu.ptr       = y_ea;
    assign y_agu.byte_op   = 1'b0;
    assign y_agu.is_write  = 1'b0;
    assign y_agu.is_y      = 1'b1;
    assign y_agu.mod_en    = Y_MOD_EN_I;
    assign y_agu.mod_start = Y_MOD_START_I;
    assign y_agu.mod_end   = Y_MOD_END_I;
    assign y_agu.brev_en   = 1'b0;
    assign y_agu.brev_mod  = dsau_pkg::ZERO_WORD;

    dsau_agu u_x_agu (
        .bus (x_agu.agu)
    );

    dsau_agu u_y_agu (
        .bus (y_agu.agu)
    );

    //--------------------------------------------------------------
    // Stretch counter and held window access
    //--------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            cnt_reg       <= dsau_pkg::EXTRA_NONE;
            pend_pm_reg   <= '0;
            pend_byte_reg <= 1'b0;
            pend_lane_reg <= 1'b0;
            pend_hi_reg   <= 8'h00;
            pend_trap_reg <= 1'b0;
        end else if (accept && (extra != dsau_pkg::EXTRA_NONE)) begin
            cnt_reg       <= extra;
            pend_pm_reg   <= pm_addr_now;
            pend_byte_reg <= REQ_BYTE_I;
            pend_lane_reg <= x_ea[0];
            pend_hi_reg   <= WREG_OLD_I[15:8];
            pend_trap_reg <= misalign;
        end else if (!REQ_READY_O) begin
            cnt_reg <= cnt_reg - 2'h1;
        end
    end

    //--------------------------------------------------------------
    // Read results
    //--------------------------------------------------------------
    // Results land once the access has its data
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            resp_valid_reg <= 1'b0;
            x_rdata_reg    <= dsau_pkg::ZERO_WORD;
            y_rdata_reg    <= dsau_pkg::ZERO_WORD;
            load_reg       <= dsau_pkg::ZERO_WORD;
            trap_reg       <= 1'b0;
        end else if (accept && (extra == dsau_pkg::EXTRA_NONE)) begin
            resp_valid_reg <= 1'b1;
            x_rdata_reg    <= x_fmt;
            load_reg       <= load_fmt;
            y_rdata_reg    <= (mac_rd && y_in_y) ? YRAM_RDATA_I
                                 : dsau_pkg::ZERO_WORD;
            trap_reg       <= misalign;
        end else if (accept) begin
            resp_valid_reg <= 1'b0;
            trap_reg       <= 1'b0;
            y_rdata_reg    <= (mac_rd && y_in_y) ? YRAM_RDATA_I
                                 : dsau_pkg::ZERO_WORD;
        end else if (cnt_reg == dsau_pkg::EXTRA_SHORT) begin
            resp_valid_reg <= 1'b1;
            trap_reg       <= pend_trap_reg;
            if (pend_byte_reg) begin
                x_rdata_reg <= {8'h00, pend_lane_reg ? PM_RDATA_I[15:8]
                                          : PM_RDATA_I[7:0]};
                load_reg    <= {pend_hi_reg, pend_lane_reg
                                ? PM_RDATA_I[15:8]
                                : PM_RDATA_I[7:0]};
            end else begin
                x_rdata_reg <= PM_RDATA_I[15:0];
                load_reg    <= PM_RDATA_I[15:0];
            end
        end else begin
            resp_valid_reg <= 1'b0;
            trap_reg       <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // X write path and pointer updates
    //--------------------------------------------------------------
    // The only write path; misaligned or unmapped writes are dropped
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            we_reg    <= dsau_pkg::LANE_NONE;
            waddr_reg <= '0;
            wdata_reg <= dsau_pkg::ZERO_WORD;
        end else if (accept && REQ_WRITE_I) begin
            we_reg    <= (misalign || !ram_hit) ? dsau_pkg::LANE_NONE
                                                : lanes;
            waddr_reg <= x_ea[15:1];
            wdata_reg <= REQ_BYTE_I ? {2{REQ_WDATA_I[7:0]}}
                                    : REQ_WDATA_I;
        end else begin
            we_reg <= dsau_pkg::LANE_NONE;
        end
    end

    // Pointer values after post-modification
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            x_next_reg <= dsau_pkg::ZERO_WORD;
            y_next_reg <= dsau_pkg::ZERO_WORD;
        end else if (accept) begin
            x_next_reg <= x_agu.ptr_next;
            y_next_reg <= y_agu.ptr_next;
        end
    end

    assign RESP_VALID_O    = resp_valid_reg;
    assign X_RDATA_O       = x_rdata_reg;
    assign Y_RDATA_O       = y_rdata_reg;
    assign LOAD_DATA_O     = load_reg;
    assign ADDR_ERR_TRAP_O = trap_reg;
    assign X_PTR_NEXT_O    = x_next_reg;
    assign Y_PTR_NEXT_O    = y_next_reg;
    assign RAM_WE_O        = we_reg;
    assign RAM_WADDR_O     = waddr_reg;
    assign RAM_WDATA_O     = wdata_reg;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    a_win_short: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && win_rd && !IN_REPEAT_I && REQ_SHORT_I
        |=> !REQ_READY_O ##1 (REQ_READY_O && RESP_VALID_O))
        else $error("short window stretch wrong");

    a_win_long: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && win_rd && !IN_REPEAT_I && !REQ_SHORT_I
        |=> !REQ_READY_O [*2] ##1 (REQ_READY_O && RESP_VALID_O))
        else $error("long window stretch wrong");

    // Edge flag is judged at the accept cycle, not after it
    a_repeat_cost: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && win_rd && IN_REPEAT_I && REPEAT_EDGE_I
        |=> !REQ_READY_O [*2] ##1 (REQ_READY_O && RESP_VALID_O))
        else $error("repeat edge window timing wrong");

    a_repeat_fast: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && win_rd && IN_REPEAT_I && !REPEAT_EDGE_I
        |=> REQ_READY_O && RESP_VALID_O)
        else $error("repeat window not single cycle");

    a_pm_address: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && win_rd |-> PM_RD_O &&
        PM_ADDR_O[22:15] == PROGRAM_WINDOW_PAGE_I &&
        PM_ADDR_O[14:1] == x_ea[14:1])
        else $error("program address wrong");

    a_table_mute: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && TABLE_ACTIVE_I |=> REQ_READY_O && RESP_VALID_O)
        else $error("window active during table access");

    a_zero_invalid: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && !REQ_WRITE_I && x_invalid
        |=> X_RDATA_O == dsau_pkg::ZERO_WORD)
        else $error("invalid read not zero");

    a_write_cause: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        RAM_WE_O != dsau_pkg::LANE_NONE
        |-> $past(accept && REQ_WRITE_I))
        else $error("write without write request");

    a_byte_lane: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && REQ_WRITE_I && REQ_BYTE_I && ram_hit
        |=> RAM_WE_O == ($past(x_ea[0]) ? dsau_pkg::LANE_HIGH
                                        : dsau_pkg::LANE_LOW))
        else $error("byte write lane wrong");

    a_misalign_trap: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && REQ_WRITE_I && misalign
        |=> RAM_WE_O == dsau_pkg::LANE_NONE && ADDR_ERR_TRAP_O)
        else $error("misaligned write not trapped");

    a_trap_pulse: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        ADDR_ERR_TRAP_O |-> RESP_VALID_O
        ##1 (!ADDR_ERR_TRAP_O || $past(accept && misalign)))
        else $error("trap not a single pulse");

    a_post_step: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_N_I)
        accept && !X_MOD_EN_I && !(BREV_EN_I && REQ_WRITE_I)
        |=> X_PTR_NEXT_O == $past(x_ea) +
            ($past(REQ_BYTE_I) ? dsau_pkg::STEP_BYTE
                               : dsau_pkg::STEP_WORD))
        else $error("post increment step wrong");
endmodule

// File: verification/dsau_mem_model.sv
// Purpose: Memory far side: data RAM, Y RAM and program memory.
// Assumes: Reads answer in the same cycle as the address.
// Notes:   Contents are address patterns the bench can recompute.
module dsau_mem_model (
    input  wire logic        clk_i,
    input  wire logic [14:0] raddr_i,
    input  wire logic [14:0] yaddr_i,
    input  wire logic [23:0] pm_addr_i,
    input  wire logic        pm_rd_i,
    output logic      [15:0] rdata_o,
    output logic      [15:0] ydata_o,
    output logic      [23:0] pm_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flip_reg = 1'b0;

    // Toggles so an unread program bus never looks stable
    always @(posedge clk_i) begin
        flip_reg <= ~flip_reg;
    end

    // Word patterns; the upper program byte is non-zero to catch leaks
    assign rdata_o = {~raddr_i[7:0], raddr_i[7:0]};
    assign ydata_o = {8'hc3 ^ yaddr_i[7:0], yaddr_i[7:0]};
    assign pm_data_o = pm_rd_i ? {8'hee, pm_addr_i[15:0] ^ 16'h5a5a}
                               : 24'h5a5a5a ^ {24{flip_reg}};
endmodule

// File: verification/tb.sv
// Purpose: Self-checking bench of the data-space access unit.
// Assumes: Inputs change 2 ns after the rising clock edge.
// Notes:   Bit reverse is exercised on one X write; one read checks that it stays off.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic SYS_CLK_I = 1'b0, RST_N_I = 1'b0, REQ_VALID_I = 1'b0;
    logic REQ_WRITE_I = 1'b0, REQ_BYTE_I = 1'b0, REQ_MAC_I = 1'b0;
    logic REQ_SHORT_I = 1'b0, REQ_XPTR_SEL_I = 1'b0, REQ_YPTR_SEL_I = 1'b0;
    logic TABLE_ACTIVE_I = 1'b0, IN_REPEAT_I = 1'b0, REPEAT_EDGE_I = 1'b0;
    logic PROGRAM_WINDOW_ENABLE_I = 1'b0, X_MOD_EN_I = 1'b0;
    logic BREV_EN_I = 1'b0, Y_MOD_EN_I = 1'b0;
    logic [7:0]  PROGRAM_WINDOW_PAGE_I = 8'h00;
    logic [15:0] REQ_EA_I = 16'h0, REQ_WDATA_I = 16'h0, WREG_OLD_I = 16'h0;
    logic [15:0] X_POINTER_A_I = 16'h0, X_POINTER_B_I = 16'h0;
    logic [15:0] Y_POINTER_A_I = 16'h0, Y_POINTER_B_I = 16'h0;
    logic [15:0] X_MOD_START_I = 16'h0, X_MOD_END_I = 16'h0;
    logic [15:0] Y_MOD_START_I = 16'h0, Y_MOD_END_I = 16'h0;
    logic [15:0] BREV_MOD_I = 16'h0;
    logic        REQ_READY_O, RESP_VALID_O, ADDR_ERR_TRAP_O, PM_RD_O, prd;
    logic [15:0] X_RDATA_O, Y_RDATA_O, LOAD_DATA_O, X_PTR_NEXT_O;
    logic [15:0] Y_PTR_NEXT_O, RAM_WDATA_O, RAM_RDATA_I, YRAM_RDATA_I;
    logic [14:0] RAM_RADDR_O, YRAM_RADDR_O, RAM_WADDR_O;
    logic [1:0]  RAM_WE_O;
    logic [23:0] PM_ADDR_O, PM_RDATA_I, pa, lat;
    int          err_count = 0, checked = 0, cyc = 0;

    dsau_top dsau_top_i (.*);
    dsau_mem_model dsau_mem_model_i (
        .clk_i     (SYS_CLK_I),
        .raddr_i   (RAM_RADDR_O),
        .yaddr_i   (YRAM_RADDR_O),
        .pm_addr_i (PM_ADDR_O),
        .pm_rd_i   (PM_RD_O),
        .rdata_o   (RAM_RDATA_I),
        .ydata_o   (YRAM_RDATA_I),
        .pm_data_o (PM_RDATA_I)
    );

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    always #25 SYS_CLK_I = ~SYS_CLK_I;

    // Ceiling far above the sixty-odd cycles the run needs
    always @(posedge SYS_CLK_I) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end

    function automatic logic [15:0] rw(input logic [15:0] ea);
        return {~ea[8:1], ea[8:1]};
    endfunction

    task automatic chk(input string n, input logic [23:0] e, g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    // One request; the edge wait first keeps valid from two writes at once
    task automatic go();
        @(posedge SYS_CLK_I) #2;
        REQ_VALID_I = 1'b1;
        while (REQ_READY_O !== 1'b1) @(posedge SYS_CLK_I) #2;
        pa = PM_ADDR_O;
        prd = PM_RD_O;
        @(posedge SYS_CLK_I) #2;
        REQ_VALID_I = 1'b0;
        lat = 24'h1;
        while (RESP_VALID_O !== 1'b1 && lat < 24'h8) begin
            @(posedge SYS_CLK_I) #2;
            lat++;
        end
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reads();
        X_POINTER_A_I = 16'h0300;
        REQ_EA_I = 16'h0100;
        go();
        chk("latency", 24'h1, lat);
        chk("x_rdata", rw(16'h0100), X_RDATA_O);
        chk("x_ptr_next", 16'h0102, X_PTR_NEXT_O);
        REQ_BYTE_I = 1'b1;
        REQ_EA_I = 16'h0101;
        WREG_OLD_I = 16'hbeef;
        go();
        chk("x_rdata", {8'h00, rw(16'h0100) >> 8}, X_RDATA_O);
        chk("load", 16'hbe7f, LOAD_DATA_O);
        chk("x_ptr_next", 16'h0102, X_PTR_NEXT_O);
        REQ_BYTE_I = 1'b0;
        REQ_EA_I = 16'h0a10;
        go();
        chk("x_rdata", rw(16'h0a10), X_RDATA_O);
        REQ_EA_I = 16'h4000;
        go();
        chk("x_rdata", 16'h0000, X_RDATA_O);
        REQ_EA_I = 16'h0103;
        go();
        chk("trap", 1'b1, ADDR_ERR_TRAP_O);
        chk("x_rdata", rw(16'h0102), X_RDATA_O);
        @(posedge SYS_CLK_I) #2;
        chk("trap", 1'b0, ADDR_ERR_TRAP_O);
    endtask

    task automatic t_writes();
        logic [15:0] ea [4];
        logic [1:0]  we [4];
        ea = '{16'h0105, 16'h0104, 16'h0107, 16'h0a02};
        we = '{2'h2, 2'h1, 2'h0, 2'h3};
        REQ_WRITE_I = 1'b1;
        REQ_WDATA_I = 16'h00a7;
        for (int i = 0; i < 4; i++) begin
            REQ_BYTE_I = (i < 2);
            REQ_EA_I = ea[i];
            go();
            chk("ram_we", we[i], RAM_WE_O);
            chk("trap", (i == 2), ADDR_ERR_TRAP_O);
            if (i < 2) chk("ram_wdata", 16'ha7a7, RAM_WDATA_O);
            if (i != 2) chk("ram_waddr", ea[i] >> 1, RAM_WADDR_O);
        end
        BREV_EN_I = 1'b1;
        BREV_MOD_I = 16'h0010;
        REQ_EA_I = 16'h0110;
        go();
        chk("x_ptr_next", 16'h0108, X_PTR_NEXT_O);
        REQ_WRITE_I = 1'b0;
        go();
        chk("x_ptr_next", 16'h0112, X_PTR_NEXT_O);
        BREV_EN_I = 1'b0;
        REQ_BYTE_I = 1'b0;
    endtask

    task automatic t_window();
        logic [2:0]  mode [4];
        logic [23:0] lt [4];
        mode = '{3'h4, 3'h0, 3'h3, 3'h2};
        lt = '{24'h2, 24'h3, 24'h3, 24'h1};
        PROGRAM_WINDOW_ENABLE_I = 1'b1;
        PROGRAM_WINDOW_PAGE_I = 8'h3c;
        REQ_EA_I = 16'h8246;
        for (int i = 0; i < 4; i++) begin
            {REQ_SHORT_I, IN_REPEAT_I, REPEAT_EDGE_I} = mode[i];
            go();
            chk("latency", lt[i], lat);
            chk("pm_addr", {1'b0, 8'h3c, 14'h0123, 1'b0}, pa);
            chk("x_rdata", 16'h581c, X_RDATA_O);
        end
        {REQ_SHORT_I, IN_REPEAT_I, REPEAT_EDGE_I} = 3'h0;
        REQ_BYTE_I = 1'b1;
        REQ_EA_I = 16'h8247;
        go();
        chk("latency", 24'h3, lat);
        chk("x_rdata", 16'h0058, X_RDATA_O);
        chk("load", 16'hbe58, LOAD_DATA_O);
        TABLE_ACTIVE_I = 1'b1;
        go();
        chk("pm_rd", 1'b0, prd);
        chk("x_rdata", 16'h0000, X_RDATA_O);
        TABLE_ACTIVE_I = 1'b0;
        PROGRAM_WINDOW_ENABLE_I = 1'b0;
        go();
        chk("latency", 24'h1, lat);
        chk("x_rdata", 16'h0000, X_RDATA_O);
        REQ_BYTE_I = 1'b0;
    endtask

    task automatic t_mac();
        REQ_MAC_I = 1'b1;
        REQ_XPTR_SEL_I = 1'b1;
        X_POINTER_B_I = 16'h0200;
        Y_POINTER_A_I = 16'h0900;
        go();
        chk("x_rdata", rw(16'h0200), X_RDATA_O);
        chk("y_rdata", {8'hc3 ^ 8'h80, 8'h80}, Y_RDATA_O);
        chk("y_ptr_next", 16'h0902, Y_PTR_NEXT_O);
        {X_MOD_EN_I, Y_MOD_EN_I} = 2'h3;
        {X_MOD_START_I, X_MOD_END_I} = {16'h0a00, 16'h0a00};
        {Y_MOD_START_I, Y_MOD_END_I} = {16'h0100, 16'h0200};
        X_POINTER_B_I = 16'h0a00;
        Y_POINTER_A_I = 16'h0200;
        go();
        chk("x_rdata", 16'h0000, X_RDATA_O);
        chk("y_rdata", 16'h0000, Y_RDATA_O);
        chk("x_ptr_next", 16'h0a00, X_PTR_NEXT_O);
        chk("y_ptr_next", 16'h0100, Y_PTR_NEXT_O);
        {REQ_XPTR_SEL_I, REQ_YPTR_SEL_I} = 2'h1;
        Y_POINTER_B_I = 16'h0a04;
        go();
        chk("x_rdata", rw(16'h0300), X_RDATA_O);
        chk("y_rdata", {8'hc3 ^ 8'h02, 8'h02}, Y_RDATA_O);
        REQ_MAC_I = 1'b0;
    endtask

    task automatic finish_test();
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset for ten cycles, idle outputs checked while it is held
    initial begin
        repeat (10) @(posedge SYS_CLK_I);
        #2;
        chk("ready", 1'b1, REQ_READY_O);
        chk("ram_we", 2'h0, RAM_WE_O);
        RST_N_I = 1'b1;
        t_reads();
        t_writes();
        t_window();
        t_mac();
        finish_test();
    end
endmodule
